/* File: design/vts_regs.vh */
/* Register map and timing constants. Assumes inclusion by name. */
`ifndef VTS_REGS_VH
`define VTS_REGS_VH

`define VTS_ADDR_CTRL   8'h00
`define VTS_ADDR_VTH    8'h04
`define VTS_ADDR_ITH    8'h08
`define VTS_ADDR_NOM    8'h0c
`define VTS_ADDR_STAT   8'h10

`define VTS_CTRL_RST    32'h0000_0001
`define VTS_VTH_RST     32'h003c_0a1e
`define VTS_ITH_RST     32'h000a_0a0a
`define VTS_NOM_RST     32'h1000_1000
`define VTS_CTRL_MASK   32'h0000_000f

`define VTS_MODE_MSB    1
`define VTS_MODE_LSB    0
`define VTS_DLD_ON_BIT  2
`define VTS_DLD_BLK_BIT 3
`define VTS_RES_MSB     7
`define VTS_RES_LSB     0
`define VTS_NEG_MSB     15
`define VTS_NEG_LSB     8
`define VTS_DLD_MSB     23
`define VTS_DLD_LSB     16
`define VTS_NOMV_MSB    15
`define VTS_NOMV_LSB    0
`define VTS_NOMI_MSB    31
`define VTS_NOMI_LSB    16

`define VTS_MODE_OFF    2'h0
`define VTS_MODE_ZERO   2'h1
`define VTS_MODE_NEG    2'h2
`define VTS_MODE_SPEC   2'h3

`define VTS_CLK_KHZ     25000
`define VTS_LIVE_MS     200
`define VTS_QUAL_MS     4
`define VTS_RESET_MS    200
`define VTS_LATCH_MS    100
`define VTS_TW          23

`define VTS_DFT_LAST    4'hf
`define VTS_ROT_K       32'sh377
`define VTS_ROT_HALF    32'sh200
`define VTS_ROT_SH      10
`define VTS_PCT_SCALE   32'h64

`endif

/* File: design/vts_fourier.v */
/* One-channel 16-point DFT phasor. Assumes 16 strobes a period. */
`timescale 1ns/1ps
`default_nettype none
`include "vts_regs.vh"

module vts_fourier (
    // Clock and reset
    input  wire               hclk,
    input  wire               hresetn,
    // Sample in
    input  wire               sample_en,
    input  wire signed [15:0] sample,
    // Phasor out
    output reg  signed [15:0] ph_re,
    output reg  signed [15:0] ph_im,
    output reg                ph_valid
);

    reg        [3:0]  idx;
    reg signed [27:0] acc_re;
    reg signed [27:0] acc_im;

    function signed [7:0] coef;
        input [3:0] k;
        reg signed [7:0] c;
        begin
            case (k[2:0])
                3'h0: c = 8'sh7f;
                3'h1: c = 8'sh75;
                3'h2: c = 8'sh5a;
                3'h3: c = 8'sh31;
                3'h4: c = 8'sh00;
                3'h5: c = 8'shcf;
                3'h6: c = 8'sha6;
                default: c = 8'sh8b;
            endcase
            coef = k[3] ? -c : c;
        end
    endfunction

    wire signed [23:0] p_re = sample * coef(idx);
    // Minus sine is cosine shifted a quarter period ahead
    wire signed [23:0] p_im = sample * coef(idx + 4'h4);
    wire signed [27:0] s_re = acc_re + {{4{p_re[23]}}, p_re};
    wire signed [27:0] s_im = acc_im + {{4{p_im[23]}}, p_im};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx      <= 4'h0;
            acc_re   <= 28'sh0;
            acc_im   <= 28'sh0;
            ph_re    <= 16'sh0;
            ph_im    <= 16'sh0;
            ph_valid <= 1'b0;
        end else begin
            ph_valid <= sample_en && (idx == `VTS_DFT_LAST);
            if (sample_en) begin
                idx    <= idx + 4'h1;
                acc_re <= (idx == `VTS_DFT_LAST) ? 28'sh0 : s_re;
                acc_im <= (idx == `VTS_DFT_LAST) ? 28'sh0 : s_im;
            end
            if (sample_en && idx == `VTS_DFT_LAST) begin
                ph_re <= s_re[26:11];
                ph_im <= s_im[26:11];
            end
        end
    end

endmodule // vts_fourier

`default_nettype wire

/* File: design/vts_seq.v */
/* Residual and negative-sequence phasors, times three.
   Assumes phasors stable when upd pulses. */
`timescale 1ns/1ps
`default_nettype none
`include "vts_regs.vh"

module vts_seq (
    // Clock and reset
    input  wire               hclk,
    input  wire               hresetn,
    // Phase phasors
    input  wire               upd,
    input  wire signed [15:0] a_re,
    input  wire signed [15:0] a_im,
    input  wire signed [15:0] b_re,
    input  wire signed [15:0] b_im,
    input  wire signed [15:0] c_re,
    input  wire signed [15:0] c_im,
    // Sequence phasors
    output reg  signed [17:0] res_re,
    output reg  signed [17:0] res_im,
    output reg  signed [17:0] neg_re,
    output reg  signed [17:0] neg_im
);

    // dir 1 rotates by +120 degrees, dir 0 by +240 degrees
    function signed [31:0] rot_re;
        input signed [15:0] x;
        input signed [15:0] y;
        input               dir;
        rot_re = (dir ? -(x * `VTS_ROT_HALF) - y * `VTS_ROT_K
                      : -(x * `VTS_ROT_HALF) + y * `VTS_ROT_K) >>> `VTS_ROT_SH;
    endfunction

    function signed [31:0] rot_im;
        input signed [15:0] x;
        input signed [15:0] y;
        input               dir;
        rot_im = (dir ? x * `VTS_ROT_K - y * `VTS_ROT_HALF
                      : -(x * `VTS_ROT_K) - y * `VTS_ROT_HALF) >>> `VTS_ROT_SH;
    endfunction

    wire signed [31:0] sr = a_re + b_re + c_re;
    wire signed [31:0] si = a_im + b_im + c_im;
    wire signed [31:0] nr = a_re + rot_re(b_re, b_im, 1'b0) + rot_re(c_re, c_im, 1'b1);
    wire signed [31:0] ni = a_im + rot_im(b_re, b_im, 1'b0) + rot_im(c_re, c_im, 1'b1);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_re <= 18'sh0;
            res_im <= 18'sh0;
            neg_re <= 18'sh0;
            neg_im <= 18'sh0;
        end else if (upd) begin
            res_re <= sr[17:0]; // RULE13
            res_im <= si[17:0];
            neg_re <= nr[17:0]; // RULE12
            neg_im <= ni[17:0];
        end
    end

endmodule // vts_seq

`default_nettype wire

/* File: design/vts_supervision.v */
/*
 Transformer secondary-circuit supervision with line-state detection,
 AHB-Lite register slave. Assumes synchronous sample strobe and data.
*/
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
// What this block does
// (RULE1) Zero mode: residual V high, residual I low
// (RULE2) Negative mode: negative V high, negative I low
// (RULE3) Special: residual V high, both currents low
// (RULE4) Enable only after 200 ms continuous live
// (RULE5) Dead line makes supervision inactive, unless latched
// (RULE6) Flag after condition held 4 ms
// (RULE7) Runs only with detector enabled, unblocked
// (RULE8) Condition gone while live: clear after 200 ms
// (RULE9) Flag held 100 ms stays latched through dead
// (RULE10) Flag younger than 100 ms clears on dead
// (RULE11) Fundamental phasor for each of six channels
// (RULE12) Negative-sequence voltage and current phasors
// (RULE13) Residual voltage and current phasors
// (RULE14) Decision stage combines condition and line state
// (RULE15) Outputs: fault flag, live, dead indications
// (RULE16) Dead: all voltages and currents below thresholds
// (RULE17) Live: all voltages above threshold
// (RULE18) Modes off, zero, negative, special; zero default
// (RULE19) Software keeps thresholds in documented ranges
// (RULE20) Timers in clock ticks, cleared by reset/off
// (RULE21) Latched flag released only by live reset path
`timescale 1ns/1ps
`default_nettype none
`include "vts_regs.vh"

module vts_supervision #(
    parameter [`VTS_TW-1:0] LIVE_CYC  = `VTS_LIVE_MS * `VTS_CLK_KHZ,
    parameter [`VTS_TW-1:0] QUAL_CYC  = `VTS_QUAL_MS * `VTS_CLK_KHZ,
    parameter [`VTS_TW-1:0] RESET_CYC = `VTS_RESET_MS * `VTS_CLK_KHZ,
    parameter [`VTS_TW-1:0] LATCH_CYC = `VTS_LATCH_MS * `VTS_CLK_KHZ
) (
    // Clock and reset
    input  wire               hclk,
    input  wire               hresetn,
    // AHB-Lite slave
    input  wire               hsel,
    input  wire        [31:0] haddr,
    input  wire        [1:0]  htrans,
    input  wire               hwrite,
    input  wire        [2:0]  hsize,
    input  wire        [31:0] hwdata,
    input  wire               hready,
    output wire               hreadyout,
    output wire               hresp,
    output reg         [31:0] hrdata,
    // Sampled measurements
    input  wire               sample_en,
    input  wire signed [15:0] va,
    input  wire signed [15:0] vb,
    input  wire signed [15:0] vc,
    input  wire signed [15:0] ia,
    input  wire signed [15:0] ib,
    input  wire signed [15:0] ic,
    // Status out
    output reg                secondary_fault_flag,
    output reg                live_line,
    output reg                dead_line
);

    localparam [4:0] ST_OFF    = 5'h01;
    localparam [4:0] ST_WAIT   = 5'h02;
    localparam [4:0] ST_ACTIVE = 5'h04;
    localparam [4:0] ST_FAIL   = 5'h08;
    localparam [4:0] ST_LATCH  = 5'h10;

    reg [31:0] ctrl;
    reg [31:0] vth;
    reg [31:0] ith;
    reg [31:0] nom;
    reg        ap_wr;
    reg        rd_wait;
    reg [7:0]  ap_addr;
    reg [31:0] rd_mux;

    reg [4:0]  state;
    reg [4:0]  next_state;
    reg        cond;
    reg [`VTS_TW-1:0] live_cnt;
    reg [`VTS_TW-1:0] cond_cnt;
    reg [`VTS_TW-1:0] rst_cnt;
    reg [`VTS_TW-1:0] age_cnt;

    function [18:0] mag;
        input signed [17:0] re;
        input signed [17:0] im;
        reg [18:0] ar;
        reg [18:0] ai;
        begin
            ar  = re[17] ? (19'h0 - {re[17], re}) : {1'b0, re};
            ai  = im[17] ? (19'h0 - {im[17], im}) : {1'b0, im};
            // Max plus half min: cheap magnitude, never low and at most about 12 percent high
            mag = (ar > ai) ? (ar + {1'b0, ai[18:1]}) : (ai + {1'b0, ar[18:1]});
        end
    endfunction

    function above;
        input [18:0] m;
        input [7:0]  pct;
        input [15:0] nomv;
        reg [31:0] l;
        reg [31:0] r;
        begin
            l     = {13'h0, m} * `VTS_PCT_SCALE;
            r     = {24'h0, pct} * {16'h0, nomv};
            above = (l > r);
        end
    endfunction

    // Bus side
    wire accept = hsel & hready & htrans[1];
    assign hreadyout = ~rd_wait;
    assign hresp     = 1'b0;

    always @* begin
        case (ap_addr)
            `VTS_ADDR_CTRL: rd_mux = ctrl;
            `VTS_ADDR_VTH:  rd_mux = vth;
            `VTS_ADDR_ITH:  rd_mux = ith;
            `VTS_ADDR_NOM:  rd_mux = nom;
            `VTS_ADDR_STAT: rd_mux = {23'h0, state, cond, dead_line, live_line,
                                      secondary_fault_flag};
            default:        rd_mux = 32'h0;
        endcase
    end

    // One wait state on reads so a read right after a write sees it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr   <= 1'b0;
            rd_wait <= 1'b0;
            ap_addr <= 8'h0;
            hrdata  <= 32'h0;
            ctrl    <= `VTS_CTRL_RST; // RULE18
            vth     <= `VTS_VTH_RST;
            ith     <= `VTS_ITH_RST;
            nom     <= `VTS_NOM_RST;
        end else begin
            if (rd_wait) begin
                rd_wait <= 1'b0;
                hrdata  <= rd_mux;
            end
            if (ap_wr && hready) begin
                case (ap_addr)
                    `VTS_ADDR_CTRL: ctrl <= hwdata & `VTS_CTRL_MASK;
                    `VTS_ADDR_VTH:  vth  <= hwdata;
                    `VTS_ADDR_ITH:  ith  <= hwdata;
                    `VTS_ADDR_NOM:  nom  <= hwdata;
                    default:        ;
                endcase
            end
            if (accept) begin
                ap_wr   <= hwrite;
                rd_wait <= ~hwrite;
                ap_addr <= haddr[7:0];
            end else if (hready) begin
                ap_wr <= 1'b0;
            end
        end
    end

    wire [1:0]  mode    = ctrl[`VTS_MODE_MSB:`VTS_MODE_LSB];
    wire        dld_run = ctrl[`VTS_DLD_ON_BIT] & ~ctrl[`VTS_DLD_BLK_BIT];
    wire        run     = dld_run & (mode != `VTS_MODE_OFF); // RULE7
    wire [15:0] nom_v   = nom[`VTS_NOMV_MSB:`VTS_NOMV_LSB];
    wire [15:0] nom_i   = nom[`VTS_NOMI_MSB:`VTS_NOMI_LSB];

    // Phasor front end
    wire [95:0] samp = {ic, ib, ia, vc, vb, va};
    wire [95:0] ph_re;
    wire [95:0] ph_im;
    wire [5:0]  ph_valid;
    wire [5:0]  ph_hi;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_ch
            vts_fourier u_dft ( // RULE11
                .hclk      (hclk),
                .hresetn   (hresetn),
                .sample_en (sample_en),
                .sample    (samp[g*16 +: 16]),
                .ph_re     (ph_re[g*16 +: 16]),
                .ph_im     (ph_im[g*16 +: 16]),
                .ph_valid  (ph_valid[g])
            );
            assign ph_hi[g] = above(mag({{2{ph_re[g*16+15]}}, ph_re[g*16 +: 16]},
                                        {{2{ph_im[g*16+15]}}, ph_im[g*16 +: 16]}),
                                    (g < 3) ? vth[`VTS_DLD_MSB:`VTS_DLD_LSB]
                                            : ith[`VTS_DLD_MSB:`VTS_DLD_LSB],
                                    (g < 3) ? nom_v : nom_i);
        end
    endgenerate

    wire        upd = &ph_valid;
    wire [17:0] rv_re;
    wire [17:0] rv_im;
    wire [17:0] nv_re;
    wire [17:0] nv_im;
    wire [17:0] ri_re;
    wire [17:0] ri_im;
    wire [17:0] ni_re;
    wire [17:0] ni_im;

    vts_seq u_vseq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .upd     (upd),
        .a_re    (ph_re[15:0]),
        .a_im    (ph_im[15:0]),
        .b_re    (ph_re[31:16]),
        .b_im    (ph_im[31:16]),
        .c_re    (ph_re[47:32]),
        .c_im    (ph_im[47:32]),
        .res_re  (rv_re),
        .res_im  (rv_im),
        .neg_re  (nv_re),
        .neg_im  (nv_im)
    );

    vts_seq u_iseq (
        .hclk    (hclk),
        .hresetn (hresetn),
        .upd     (upd),
        .a_re    (ph_re[63:48]),
        .a_im    (ph_im[63:48]),
        .b_re    (ph_re[79:64]),
        .b_im    (ph_im[79:64]),
        .c_re    (ph_re[95:80]),
        .c_im    (ph_im[95:80]),
        .res_re  (ri_re),
        .res_im  (ri_im),
        .neg_re  (ni_re),
        .neg_im  (ni_im)
    );

    wire rv_hi = above(mag(rv_re, rv_im), vth[`VTS_RES_MSB:`VTS_RES_LSB], nom_v);
    wire ri_hi = above(mag(ri_re, ri_im), ith[`VTS_RES_MSB:`VTS_RES_LSB], nom_i);
    wire nv_hi = above(mag(nv_re, nv_im), vth[`VTS_NEG_MSB:`VTS_NEG_LSB], nom_v);
    wire ni_hi = above(mag(ni_re, ni_im), ith[`VTS_NEG_MSB:`VTS_NEG_LSB], nom_i);

    reg next_cond;
    always @* begin
        case (mode)
            `VTS_MODE_ZERO: next_cond = rv_hi & ~ri_hi;          // RULE1
            `VTS_MODE_NEG:  next_cond = nv_hi & ~ni_hi;          // RULE2
            `VTS_MODE_SPEC: next_cond = rv_hi & ~ri_hi & ~ni_hi; // RULE3
            default:        next_cond = 1'b0;
        endcase
    end

    // Decision stage
    always @* begin
        case (state)
            ST_OFF:
                next_state = ST_WAIT;
            ST_WAIT:
                next_state = (live_line && live_cnt == LIVE_CYC - 1'b1)
                             ? ST_ACTIVE : ST_WAIT; // RULE4
            ST_ACTIVE:
                if (dead_line)
                    next_state = ST_WAIT; // RULE5
                else if (cond && cond_cnt == QUAL_CYC - 1'b1)
                    next_state = ST_FAIL; // RULE6
                else
                    next_state = ST_ACTIVE;
            ST_FAIL:
                if (dead_line)
                    next_state = (age_cnt == LATCH_CYC) ? ST_LATCH : ST_WAIT; // RULE9 RULE10
                else if (!cond && live_line && rst_cnt == RESET_CYC - 1'b1)
                    next_state = ST_ACTIVE; // RULE8
                else
                    next_state = ST_FAIL;
            ST_LATCH:
                next_state = live_line ? ST_FAIL : ST_LATCH; // RULE21
            default:
                next_state = ST_OFF;
        endcase
        if (!run)
            next_state = ST_OFF; // RULE7
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state                <= ST_OFF;
            cond                 <= 1'b0;
            live_line            <= 1'b0;
            dead_line            <= 1'b0;
            secondary_fault_flag <= 1'b0;
            live_cnt             <= {`VTS_TW{1'b0}};
            cond_cnt             <= {`VTS_TW{1'b0}};
            rst_cnt              <= {`VTS_TW{1'b0}};
            age_cnt              <= {`VTS_TW{1'b0}};
        end else begin
            state     <= next_state;
            cond      <= next_cond & run;
            live_line <= dld_run & (&ph_hi[2:0]);     // RULE17 RULE15
            dead_line <= dld_run & ~(|ph_hi);         // RULE16 RULE15
            secondary_fault_flag <= (next_state == ST_FAIL) ||
                                    (next_state == ST_LATCH); // RULE14 RULE15
            // Timers saturate at their own end value
            if (state == ST_WAIT && live_line && live_cnt != LIVE_CYC)
                live_cnt <= live_cnt + 1'b1; // RULE20
            else if (state != ST_WAIT || !live_line)
                live_cnt <= {`VTS_TW{1'b0}};
            if (state == ST_ACTIVE && cond && cond_cnt != QUAL_CYC)
                cond_cnt <= cond_cnt + 1'b1;
            else if (state != ST_ACTIVE || !cond)
                cond_cnt <= {`VTS_TW{1'b0}};
            if (state == ST_FAIL && !cond && live_line && rst_cnt != RESET_CYC)
                rst_cnt <= rst_cnt + 1'b1;
            else if (state != ST_FAIL || cond || !live_line)
                rst_cnt <= {`VTS_TW{1'b0}};
            if (state == ST_FAIL && age_cnt != LATCH_CYC)
                age_cnt <= age_cnt + 1'b1;
            else if (state != ST_FAIL && state != ST_LATCH)
                age_cnt <= {`VTS_TW{1'b0}};
        end
    end

endmodule // vts_supervision

`default_nettype wire

/* File: verif/vts_sup_checker.sv */
/* Port checker, bound at the foot. Assumes hready is hreadyout. */
`timescale 1ns/1ps
`default_nettype none
`include "vts_regs.vh"
module vts_sup_checker #(
    parameter [`VTS_TW-1:0] LIVE_CYC  = 100,
    parameter [`VTS_TW-1:0] QUAL_CYC  = 8,
    parameter [`VTS_TW-1:0] RESET_CYC = 100,
    parameter [`VTS_TW-1:0] LATCH_CYC = 200
) (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Status
    input wire logic        secondary_fault_flag,
    input wire logic        live_line,
    input wire logic        dead_line
);
    logic [3:0]         ctrl;
    logic [3:0]         ctrl_d;
    logic               wr_c;
    logic [`VTS_TW-1:0] live_run;
    logic [`VTS_TW-1:0] arm;
    logic [`VTS_TW-1:0] age;
    wire                det = ctrl[2] & ~ctrl[3];
    wire                ok  = det & (ctrl[1:0] != 2'h0);
    wire                fl  = secondary_fault_flag;
    // Control word shadow
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= 4'h1;
            ctrl_d <= 4'h1;
            wr_c <= 1'b0;
            live_run <= '0;
            arm <= '0;
            age <= '0;
        end else begin
            ctrl_d <= ctrl;
            if (hready)
                wr_c <= hsel & htrans[1] & hwrite & (haddr[7:0] == `VTS_ADDR_CTRL);
            if (wr_c & hready)
                ctrl <= hwdata[3:0];
            live_run <= (live_line & ok) ? live_run + 1'b1 : '0;
            if (!ok | dead_line)
                arm <= '0;
            else if (arm != '0 || live_run >= LIVE_CYC)
                arm <= arm + 1'b1;
            age <= fl ? age + 1'b1 : '0;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_HRESP: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    AST_RD_WAIT: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    AST_WR_ZERO: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write wait seen");
    AST_EXCL: assert property (!(live_line && dead_line))
        else $error("live and dead");
    AST_DET_OFF: assert property (!det && !(ctrl_d[2] && !ctrl_d[3])
        |-> !fl && !live_line && !dead_line) else $error("detector off");
    AST_MODE_OFF: assert property (ctrl[1:0] == 2'h0 && ctrl_d[1:0] == 2'h0 |-> !fl)
        else $error("flag in off mode");
    AST_QUAL: assert property ($rose(fl) |-> arm >= QUAL_CYC - 1 && !dead_line)
        else $error("flag too early");
    AST_YOUNG: assert property ($rose(dead_line) && fl && age < LATCH_CYC
        |-> ##[0:2] !fl) else $error("young flag kept");
    AST_LATCH: assert property ($rose(dead_line) && fl && age > LATCH_CYC + 2
        |=> fl [*8]) else $error("old flag dropped");
    AST_RESET: assert property ($fell(fl) && ok && !dead_line
        |-> live_run >= RESET_CYC - 1) else $error("early clear");
endmodule // vts_sup_checker
bind vts_supervision vts_sup_checker #(.LIVE_CYC(LIVE_CYC), .QUAL_CYC(QUAL_CYC),
    .RESET_CYC(RESET_CYC), .LATCH_CYC(LATCH_CYC)) u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .secondary_fault_flag,
    .live_line, .dead_line);
`default_nettype wire

/* File: verif/vts_meas_model.sv */
/* Three-phase sine source, strobe every second clock.
   Assumes the bench picks the live channels. */
`timescale 1ns/1ps
`default_nettype none
module vts_meas_model (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Scenario control
    input  wire logic [2:0] v_on,
    input  wire logic       i_on,
    // Samples
    output logic            sample_en,
    output logic [15:0]     va,
    output logic [15:0]     vb,
    output logic [15:0]     vc,
    output logic [15:0]     ia,
    output logic [15:0]     ib,
    output logic [15:0]     ic
);
    logic signed [15:0] q [8];
    logic        [3:0]  ph;
    initial q = '{16'h0000, 16'h0bf5, 16'h1619, 16'h1cdf,
                  16'h1f40, 16'h1cdf, 16'h1619, 16'h0bf5};
    function automatic logic signed [15:0] sn(input logic [3:0] k);
        sn = k[3] ? -q[k[2:0]] : q[k[2:0]];
    endfunction
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_en <= 1'b0;
            ph <= 4'h0;
        end else begin
            sample_en <= ~sample_en;
            if (sample_en)
                ph <= ph + 4'h1;
        end
    end
    // 112.5 degree steps leave a small unbalance
    wire signed [15:0] sa = v_on[0] ? sn(ph) : 16'h0000;
    wire signed [15:0] sb = v_on[1] ? sn(ph + 4'hb) : 16'h0000;
    wire signed [15:0] sc = v_on[2] ? sn(ph + 4'h5) : 16'h0000;
    wire signed [15:0] si = i_on ? sn(ph) : 16'h0000;
    // Off the strobe nothing holds the lines
    assign va = sample_en ? sa : ~sa;
    assign vb = sample_en ? sb : ~sb;
    assign vc = sample_en ? sc : ~sc;
    assign ia = sample_en ? si : ~si;
    assign ib = sample_en ? 16'h0000 : 16'hffff;
    assign ic = sample_en ? 16'h0000 : 16'hffff;
endmodule // vts_meas_model
`default_nettype wire

/* File: verif/vts_supervision_tb.sv */
/* Bench: registers, modes, line states, timers.
   Assumes the measurement model drives the samples. */
`timescale 1ns/1ps
`default_nettype none
`include "vts_regs.vh"
module vts_supervision_tb;
    localparam [`VTS_TW-1:0] LV = 100, QU = 8, RS = 100, LT = 200;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b1;
    logic        hwrite  = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [2:0]  v_on    = 3'h7;
    logic        i_on    = 1'b0;
    wire         hreadyout, hresp, sample_en, flag, live, dead;
    wire [31:0]  hrdata;
    wire [15:0]  va, vb, vc, ia, ib, ic;
    wire [2:0]   obs = {dead, live, flag};
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    always #20 hclk = ~hclk;
    vts_meas_model u_fe (.hclk, .hresetn, .v_on, .i_on, .sample_en, .va, .vb, .vc, .ia,
        .ib, .ic);
    vts_supervision #(.LIVE_CYC(LV), .QUAL_CYC(QU), .RESET_CYC(RS), .LATCH_CYC(LT)) uut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sample_en, .va, .vb, .vc, .ia,
        .ib, .ic, .secondary_fault_flag(flag), .live_line(live), .dead_line(dead));
    task automatic end_of_test;
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(nm, e, r);
    endtask
    task automatic wait_for(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (obs[s] !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic t_regs;
        rdc("ctrl", `VTS_ADDR_CTRL, `VTS_CTRL_RST);
        rdc("vth", `VTS_ADDR_VTH, `VTS_VTH_RST);
        rdc("ith", `VTS_ADDR_ITH, `VTS_ITH_RST);
        rdc("nom", `VTS_ADDR_NOM, `VTS_NOM_RST);
        rdc("stat", `VTS_ADDR_STAT, 32'h0000_0010);
        rdc("unmapped", 32'h0000_0020, 32'h0000_0000);
        wr(`VTS_ADDR_CTRL, 32'hffff_fff0);
        rdc("ctrl_mask", `VTS_ADDR_CTRL, 32'h0000_0000);
        // Wide negative threshold hides healthy unbalance
        wr(`VTS_ADDR_VTH, 32'h003c_321e);
        rdc("vth_new", `VTS_ADDR_VTH, 32'h003c_321e);
    endtask
    task automatic t_recover;
        int n;
        v_on <= 3'h7;
        i_on <= 1'b0;
        wait_for(1, 1'b1, 300, n);
        wait_for(0, 1'b0, 400, n);
        check("reset_delay", 32'h1, {31'h0, n >= RS - 2 && n < RS + 80});
    endtask
    task automatic t_run(input logic [1:0] m, input logic ion, input logic ex, input logic rc);
        int n;
        wr(`VTS_ADDR_CTRL, 32'h0);
        repeat (3) @(posedge hclk);
        check("off_outputs", 32'h0, {29'h0, flag, live, dead});
        v_on <= 3'h7;
        i_on <= ion;
        wr(`VTS_ADDR_CTRL, {29'h0, 1'b1, m});
        wait_for(1, 1'b1, 300, n);
        check("live", 32'h1, {31'h0, live});
        repeat (LV + 40) @(posedge hclk);
        v_on <= 3'h6;
        wait_for(0, 1'b1, 400, n);
        check("flag_on", {31'h0, ex}, {31'h0, flag});
        if (ex && rc)
            t_recover();
    endtask
    task automatic t_block;
        wr(`VTS_ADDR_CTRL, 32'h0000_000d);
        repeat (200) @(posedge hclk);
        check("blocked", 32'h0, {29'h0, flag, live, dead});
    endtask
    task automatic t_latch(input logic lng);
        int n;
        t_run(2'h1, 1'b0, 1'b1, 1'b0);
        if (lng)
            repeat (LT + 40) @(posedge hclk);
        v_on <= 3'h0;
        wait_for(2, 1'b1, 200, n);
        repeat (20) @(posedge hclk);
        check("dead_state", {30'h0, lng, 1'b1}, {30'h0, flag, dead});
        if (lng) begin
            i_on <= 1'b1;
            repeat (100) @(posedge hclk);
            check("dead_with_i", 32'h2, {30'h0, flag, dead});
            t_recover();
        end
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        for (int m = 0; m < 4; m++)
            t_run(m[1:0], 1'b0, m != 0, m != 0);
        for (int m = 1; m < 4; m++)
            t_run(m[1:0], 1'b1, 1'b0, 1'b0);
        t_block();
        t_latch(1'b0);
        t_latch(1'b1);
        end_of_test();
    end
endmodule // vts_supervision_tb
`default_nettype wire
